// ===== rtl/ieb_enable_bank.sv
// upper interrupt-enable bank: three enable words gating flags toward priority logic
// assumes flags and priority fields come from neighbouring logic on the same clock
`timescale 1ns/100ps
module ieb_enable_bank
  import ieb_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // interrupt sources: flags and priority-zero indications
  input  wire ieb_bank_type srcFlag,
  input  wire ieb_bank_type srcPrioZero,
  // gated requests toward priority and vectoring logic
  output ieb_bank_type      gatedReq,
  // summary interrupt
  output logic              irq
);

  // enable group
  ieb_bank_type          enable;
  ieb_bank_type          next_enable;
  // event group: sticky status and its mask
  logic [NUM_EVENTS-1:0] eventStatus;
  logic [NUM_EVENTS-1:0] next_eventStatus;
  logic [NUM_EVENTS-1:0] eventMask;
  logic [NUM_EVENTS-1:0] next_eventMask;
  // request group
  ieb_bank_type          reqComb;
  ieb_bank_type          next_gatedReq;
  // bus answer group
  logic [31:0]           next_prdata;
  logic                  next_pslverr;
  // bus phase qualifiers and shared decode
  logic                  setupPhase;
  logic                  writeAcc;
  logic                  readSetup;
  logic                  hitKnown;
  logic [31:0]           readWord;
  // event sources
  logic                  anyNewReq;
  logic                  anyBlocked;
  logic                  unimplWrite;
  logic                  statusClear;
  logic                  maskWrite;

  // merge a write into an enable word; lower two byte lanes only
  function automatic logic [15:0] mergeWord(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] merged;
    merged = old;
    if (strb[0])
    begin
      merged[7:0] = wd[7:0];
    end
    if (strb[1])
    begin
      merged[15:8] = wd[15:8];
    end
    return merged & mask;
  endfunction : mergeWord

  // does a write touch unimplemented bits in lanes 0 and 1; lanes 2 and 3 are not checked
  function automatic logic touchesUnimpl(input logic [31:0] wd, input logic [3:0] strb,
                                         input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
    return |(wd[15:0] & lanes & ~mask);
  endfunction : touchesUnimpl

  // read mux for every mapped offset; hit tells a mapped offset from a hole
  // an unmapped offset reads as zero
  function automatic logic [31:0] readValue(input logic [11:0] addr,
                                            input ieb_bank_type en,
                                            input logic [NUM_EVENTS-1:0] st,
                                            input logic [NUM_EVENTS-1:0] mk,
                                            input ieb_bank_type pz,
                                            input ieb_bank_type gq,
                                            output logic hit);
    logic [31:0] word;
    word = 32'h0000_0000;
    hit  = 1'b1;
    if (addr == OFF_ENABLE_WORD2)
    begin
      word = {16'h0000, en.word2};
    end
    else if (addr == OFF_ENABLE_WORD3)
    begin
      word = {16'h0000, en.word3};
    end
    else if (addr == OFF_ENABLE_WORD4)
    begin
      word = {16'h0000, en.word4};
    end
    // sticky status and its mask sit in the low bits
    else if (addr == OFF_EVENT_STATUS)
    begin
      word = {{(32-NUM_EVENTS){1'b0}}, st};
    end
    else if (addr == OFF_EVENT_MASK)
    begin
      word = {{(32-NUM_EVENTS){1'b0}}, mk};
    end
    else if (addr == OFF_PRIO_ZERO)
    begin
      // bit 0 only: some source has its priority field at zero
      word = {31'h0000_0000, |pz};
    end
    // read-only views of what the priority logic is offered
    else if (addr == OFF_REQ_VIEW2)
    begin
      word = {16'h0000, gq.word2};
    end
    else if (addr == OFF_REQ_VIEW3)
    begin
      word = {16'h0000, gq.word3};
    end
    else if (addr == OFF_REQ_VIEW4)
    begin
      word = {16'h0000, gq.word4};
    end
    else
    begin
      hit = 1'b0;
    end
    return word;
  endfunction : readValue

  // apb phases; pready never drops because the read word is ready from the setup edge
  assign pready     = 1'b1;
  assign setupPhase = psel && !penable;
  assign writeAcc   = psel && penable && pwrite;
  assign readSetup  = setupPhase && !pwrite;

  // decode once per cycle, shared by the answer group
  always_comb
  begin
    readWord = readValue(paddr, enable, eventStatus, eventMask, srcPrioZero, gatedReq,
                         hitKnown);
  end

  // bus answer: pslverr loads at every setup edge, prdata at a read setup edge, so both stand in the access phase
  always_comb
  begin
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    // a write setup leaves the last read word in place
    if (readSetup)
    begin
      next_prdata = readWord;
    end
    // unmapped offset answers with an error and changes nothing
    if (setupPhase && !hitKnown)
    begin
      next_pslverr = 1'b1;
    end
  end

  // bus answer registers; prdata holds until the next read
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // enable group: writes land at the access edge, lane by lane
  always_comb
  begin
    next_enable = enable;
    unimplWrite = 1'b0;
    // lanes 2 and 3 carry nothing, the words are only 16 bits wide
    if (writeAcc && paddr == OFF_ENABLE_WORD2)
    begin
      next_enable.word2 = mergeWord(enable.word2, pwdata, pstrb, IMPL_MASK_WORD2);
      unimplWrite       = touchesUnimpl(pwdata, pstrb, IMPL_MASK_WORD2);
    end
    else if (writeAcc && paddr == OFF_ENABLE_WORD3)
    begin
      next_enable.word3 = mergeWord(enable.word3, pwdata, pstrb, IMPL_MASK_WORD3);
      unimplWrite       = touchesUnimpl(pwdata, pstrb, IMPL_MASK_WORD3);
    end
    else if (writeAcc && paddr == OFF_ENABLE_WORD4)
    begin
      next_enable.word4 = mergeWord(enable.word4, pwdata, pstrb, IMPL_MASK_WORD4);
      unimplWrite       = touchesUnimpl(pwdata, pstrb, IMPL_MASK_WORD4);
    end
    // a write to any other offset falls through and leaves the enables alone
  end

  // enable registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      enable <= '{word4: RESET_ENABLE, word3: RESET_ENABLE, word2: RESET_ENABLE};
    end
    else
    begin
      enable <= next_enable;
    end
  end

  // request group: gating is combinational, the result is registered once
  always_comb
  begin
    // priority zero disables
    // a cleared enable blocks from the next cycle, no draining
    reqComb       = srcFlag & enable & ~srcPrioZero;
    next_gatedReq = reqComb;
  end

  // request registers; one cycle from flag or enable to the priority logic
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      gatedReq <= '0;
    end
    else
    begin
      gatedReq <= next_gatedReq;
    end
  end

  // event sources; the blocked event repeats while the flag waits, which is harmless
  always_comb
  begin
    // a request newly passed toward the priority logic
    anyNewReq   = |(reqComb & ~gatedReq);
    // a raised flag held back by its enable, whatever its priority-zero level
    anyBlocked  = |(srcFlag & ~enable & ~gatedReq & ~reqComb);
    // status clear and mask write use lane 0 only
    statusClear = writeAcc && paddr == OFF_EVENT_STATUS && pstrb[0];
    maskWrite   = writeAcc && paddr == OFF_EVENT_MASK && pstrb[0];
  end

  // event group next values; set wins over a write-one clear in the same cycle
  always_comb
  begin
    next_eventMask   = eventMask;
    next_eventStatus = eventStatus;
    if (maskWrite)
    begin
      next_eventMask = pwdata[NUM_EVENTS-1:0];
    end
    if (statusClear)
    begin
      next_eventStatus = eventStatus & ~pwdata[NUM_EVENTS-1:0];
    end
    next_eventStatus[EVT_GATED_RISE] = next_eventStatus[EVT_GATED_RISE] | anyNewReq;
    next_eventStatus[EVT_BLOCKED]    = next_eventStatus[EVT_BLOCKED] | anyBlocked;
    next_eventStatus[EVT_UNIMPL_WR]  = next_eventStatus[EVT_UNIMPL_WR] | unimplWrite;
  end

  // event registers; the mask resets to zero so irq stays low until software opts in
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      eventStatus <= RESET_EVENTS;
      eventMask   <= RESET_EVENTS;
    end
    else
    begin
      eventStatus <= next_eventStatus;
      eventMask   <= next_eventMask;
    end
  end

  // level interrupt; software must clear the status, masking only hides it
  assign irq = |(eventStatus & eventMask);

endmodule : ieb_enable_bank

// ===== rtl/ieb_pkg.sv
// package for the upper interrupt-enable bank: register map, masks, reset values
// assumes a 32-bit apb slave port; enable words are 16 bits in the low half
package ieb_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_ENABLE_WORD2 = 12'h000;
  localparam logic [11:0] OFF_ENABLE_WORD3 = 12'h004;
  localparam logic [11:0] OFF_ENABLE_WORD4 = 12'h008;
  localparam logic [11:0] OFF_EVENT_STATUS = 12'h00c;
  localparam logic [11:0] OFF_EVENT_MASK   = 12'h010;
  localparam logic [11:0] OFF_PRIO_ZERO    = 12'h014;
  localparam logic [11:0] OFF_REQ_VIEW2    = 12'h018;
  localparam logic [11:0] OFF_REQ_VIEW3    = 12'h01c;
  localparam logic [11:0] OFF_REQ_VIEW4    = 12'h020;
  // implemented-bit masks, unimplemented positions are zero
  localparam logic [15:0] IMPL_MASK_WORD2  = 16'hdfff;
  localparam logic [15:0] IMPL_MASK_WORD3  = 16'ha7ff;
  localparam logic [15:0] IMPL_MASK_WORD4  = 16'h00f7;
  // reset values
  localparam logic [15:0] RESET_ENABLE     = 16'h0000;
  localparam logic [2:0]  RESET_EVENTS     = 3'h0;
  // event status bit positions
  localparam int EVT_GATED_RISE  = 0;
  localparam int EVT_BLOCKED     = 1;
  localparam int EVT_UNIMPL_WR   = 2;
  localparam int NUM_EVENTS      = 3;
  // bit positions of a few named enables
  localparam int POS_TIMER6      = 15;
  localparam int POS_PWM_FAULT_A = 15;
  localparam int POS_PWM_FAULT_B = 0;

  // one group of 48 source lines, three 16-bit words
  typedef struct packed {
    logic [15:0] word4;
    logic [15:0] word3;
    logic [15:0] word2;
  } ieb_bank_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ieb_apb_req_type;
endpackage : ieb_pkg

// ===== tb/ieb_chk_sva.sv
// checker for the enable bank, sees top ports only
// assumes one clock, synchronous active-high reset
`timescale 1ns/100ps
module ieb_chk
  import ieb_pkg::*;
(
  // clock and reset
  input wire logic         clk,
  input wire logic         reset,
  // apb
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [3:0]   pstrb,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  // sources and requests
  input wire ieb_bank_type srcFlag,
  input wire ieb_bank_type srcPrioZero,
  input wire ieb_bank_type gatedReq,
  input wire logic         irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence rdW4; psel && penable && !pwrite && paddr == OFF_ENABLE_WORD4; endsequence
  sequence rdW3; psel && penable && !pwrite && paddr == OFF_ENABLE_WORD3; endsequence
  sequence offMap; psel && penable && paddr > OFF_REQ_VIEW4; endsequence
  sequence clrW2; psel && penable && pwrite && paddr == OFF_ENABLE_WORD2
    && pwdata[15:0] == 16'h0000 && pstrb[1:0] == 2'h3; endsequence
  AST_READY: assert property (pready)
    else $error("pready low");
  AST_OFFMAP: assert property (offMap |-> pslverr ##1 !pslverr)
    else $error("unmapped access error flag wrong");
  AST_RST: assert property ($fell(reset) |-> gatedReq == '0 && !irq)
    else $error("request or irq set after reset");
  AST_PRIO: assert property ((gatedReq & $past(srcPrioZero)) == '0)
    else $error("request passed with priority zero");
  AST_FLAG: assert property ((gatedReq & ~$past(srcFlag)) == '0)
    else $error("request without flag");
  AST_IMPL: assert property ((gatedReq.word4 & ~IMPL_MASK_WORD4) == 16'h0000)
    else $error("request on unimplemented word4 bit");
  AST_RD4: assert property (rdW4 |-> (prdata & ~{16'h0000, IMPL_MASK_WORD4}) == 32'h0)
    else $error("word4 unimplemented bit read one");
  AST_RD3: assert property (rdW3 |-> (prdata & ~{16'h0000, IMPL_MASK_WORD3}) == 32'h0)
    else $error("word3 unimplemented bit read one");
  AST_CLR: assert property (clrW2 |-> ##2 gatedReq.word2 == 16'h0000)
    else $error("cleared enable still passes");
endmodule : ieb_chk
bind ieb_enable_bank ieb_chk chk_u (.clk, .reset, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .srcFlag, .srcPrioZero, .gatedReq, .irq);

// ===== tb/ieb_src_model.sv
// source model: sticky flags and priority-zero levels
// assumes the bench pulses evt and ack for one cycle
`timescale 1ns/100ps
module ieb_src_model
  import ieb_pkg::*;
(
  // clock and reset
  input wire logic         clk,
  input wire logic         reset,
  // bench commands
  input wire ieb_bank_type evt,
  input wire ieb_bank_type ack,
  input wire ieb_bank_type prioOff,
  // toward the bank
  output ieb_bank_type     srcFlag,
  output ieb_bank_type     srcPrioZero
);
  ieb_bank_type next_srcFlag;
  always_comb next_srcFlag = reset ? '0 : (srcFlag | evt) & ~ack;
  // priority-zero level, registered like the real field
  always_ff @(posedge clk)
  begin
    srcFlag     <= next_srcFlag;
    srcPrioZero <= prioOff;
  end
endmodule : ieb_src_model

// ===== tb/irq_enable_bank_upper_test.sv
// bench for the enable bank: apb master, source model, checks
// assumes read data and error stand in the access phase, pready high
`timescale 1ns/100ps
module irq_enable_bank_upper_test
  import ieb_pkg::*;
;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0] pstrb = '0;
  logic e;
  ieb_bank_type evt = '0, ack = '0, prioOff = '0, srcFlag, srcPrioZero, gatedReq;
  int miscompares = 0, compares = 0;
  logic [15:0] m [3] = '{IMPL_MASK_WORD2, IMPL_MASK_WORD3, IMPL_MASK_WORD4};
  always #10 clk = ~clk;
  ieb_enable_bank dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .srcFlag, .srcPrioZero, .gatedReq, .irq);
  ieb_src_model src_u (.clk, .reset, .evt, .ack, .prioOff, .srcFlag, .srcPrioZero);
  task automatic chk(input string n, input logic [47:0] x, input logic [47:0] g);
    compares++;
    if (g !== x)
      $display("unexpected %s exp %h got %h", n, x, g);
    if (g !== x)
      miscompares++;
  endtask : chk
  // one apb transfer: answer taken at the edge where pready is seen high, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic t_regs;
    for (int i = 0; i < 3; i++)
    begin
      apb(0, 12'(4 * i), 0); chk("reset word", 0, r);
      apb(1, 12'(4 * i), 32'hffffffff); apb(0, 12'(4 * i), 0);
      chk("word", {16'h0000, m[i]}, r);
    end
    apb(0, 12'h100, 0); chk("error", 1, e);
    $display("regs done");
  endtask : t_regs
  task automatic t_gate;
    evt <= '1; @(posedge clk) evt <= '0; repeat (3) @(posedge clk);
    chk("gated", {m[2], m[1], m[0]}, gatedReq);
    apb(0, OFF_REQ_VIEW3, 0);
    chk("view3", {16'h0000, m[1]}, r);
    prioOff.word3 <= 16'hffff; repeat (3) @(posedge clk);
    chk("gated prio", {m[2], 16'h0000, m[0]}, gatedReq);
    apb(0, OFF_PRIO_ZERO, 0);
    chk("prio zero", 1, r);
    apb(1, OFF_ENABLE_WORD2, 0); @(posedge clk);
    chk("gated off", {m[2], 32'h0}, gatedReq);
    $display("gate done");
  endtask : t_gate
  task automatic t_irq;
    apb(0, OFF_EVENT_STATUS, 0);
    chk("status", 7, r);
    ack <= '1; @(posedge clk) ack <= '0;
    apb(1, OFF_EVENT_MASK, 7); apb(1, OFF_EVENT_STATUS, 7); chk("irq clr", 0, irq);
    apb(1, OFF_ENABLE_WORD4, 32'hff00); chk("irq set", 1, irq);
    apb(1, OFF_EVENT_MASK, 0); chk("irq mask", 0, irq);
    $display("irq done");
  endtask : t_irq
  // mid-run reset must clear enables and events again
  task automatic t_reset;
    apb(1, OFF_EVENT_MASK, 7);
    chk("irq before reset", 1, irq);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("irq after reset", 0, irq);
    apb(0, OFF_ENABLE_WORD3, 0);
    chk("word3 after reset", 0, r);
    $display("reset done");
  endtask : t_reset
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    t_regs;
    t_gate;
    t_irq;
    t_reset;
    end_of_test;
  end
  // watchdog far beyond the roughly 80 cycles the run needs
  initial
  begin
    #100000;
    miscompares++;
    end_of_test;
  end
endmodule : irq_enable_bank_upper_test
